// File: inc/pcmo_cfg.svh
// Register map, field positions, reset values and frame constants of the PCM output block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PCMO_CFG_SVH
`define PCMO_CFG_SVH

`define PCMO_ADDR_ATT_RIGHT   8'h48
`define PCMO_ADDR_MIX_R2L     8'h49
`define PCMO_ADDR_PLL_DIV441  8'h50
`define PCMO_ADDR_FRAC441_L   8'h51
`define PCMO_ADDR_FRAC441_H   8'h52
`define PCMO_ADDR_BCLK_DIV    8'h54
`define PCMO_ADDR_OUT_CFG     8'h55

`define PCMO_RST_ATT_RIGHT    8'h00
`define PCMO_RST_MIX_R2L      8'hFF
`define PCMO_RST_PLL_DIV441   5'h00
`define PCMO_RST_FRAC441      8'h00
`define PCMO_RST_BCLK_DIV     8'h03
`define PCMO_RST_OUT_CFG      7'h21

`define PCMO_BIT_LSB_FIRST    6
`define PCMO_BIT_JUSTIFY      5
`define PCMO_BIT_WS_POL       4
`define PCMO_BIT_FORMAT       3
`define PCMO_BIT_EDGE         2
`define PCMO_PLL_DIV_W        5
`define PCMO_ATT_MAX_STEP     8'h60
`define PCMO_SLOT_16          6'h10
`define PCMO_SLOT_WIDE        6'h20
`define PCMO_FRAME_LAST_16    6'h1F
`define PCMO_FRAME_LAST_WIDE  6'h3F

`endif

// File: inc/pcmo_pkg.sv
// Types shared by the PCM output block: configuration fields and stereo sample pair.
// Assumes the constants header is on the include path.
`include "pcmo_cfg.svh"

package pcmo_pkg;

    typedef enum logic [1:0] {
        PCMO_W16 = 2'b00,
        PCMO_W18 = 2'b01,
        PCMO_W20 = 2'b10,
        PCMO_W24 = 2'b11
    } pcmo_width_t;

    typedef struct packed {
        logic        lsb_first_select;
        logic        justify_select;
        logic        word_select_polarity;
        logic        format_select;
        logic        edge_select;
        pcmo_width_t sample_width_select;
    } pcmo_cfg_t;

    typedef struct packed {
        logic signed [23:0] left;
        logic signed [23:0] right;
    } pcmo_pair_t;

endpackage

// File: core/pcmo_atten.sv
// Combinational 1 dB step attenuator for one 24-bit signed sample.
// Assumes the caller registers the result; steps above the largest one mute.
`timescale 1ns/100ps
`include "pcmo_cfg.svh"

module pcmo_atten
(
    // Sample in and out
    input  wire logic signed [23:0] din,
    output logic signed      [23:0] dout,
    // Attenuation in dB steps
    input  wire logic        [7:0]  level
);

    logic        [7:0]  octave;
    logic        [7:0]  rest;
    logic        [16:0] gain;
    logic signed [41:0] prod;

    // Six steps make one halving, so only a small fraction table is needed
    always_comb
    begin
        octave = level / 8'h06;
        rest   = level - octave * 8'h06;
        case (rest)
            8'h00:   gain = 17'h10000;
            8'h01:   gain = 17'h0E429;
            8'h02:   gain = 17'h0CB59;
            8'h03:   gain = 17'h0B53C;
            8'h04:   gain = 17'h0A186;
            default: gain = 17'h08FF6;
        endcase
        prod = (42'(din) * $signed({25'h0000000, gain})) >>> 16;
        prod = prod >>> octave;
        if (level > `PCMO_ATT_MAX_STEP)  // see R20
            dout = 24'sh000000;           // see R02
        else
            dout = prod[23:0];            // see R01 see R03
    end

endmodule // pcmo_atten

// File: core/pcmo_top.sv
// PCM output block: level and mix registers, PLL 44.1 kHz settings, bit clock and serial framing.
// Assumes clk is the oversampling clock and the register port is driven by the control bus engine.
//
// Functional notes
// R01: Right attenuation: one dB per unit
// R02: All-ones right attenuation gives full mute
// R03: Right-to-left mix in one dB steps
// R04: Mix level resets to all ones
// R05: 44.1k divider: five bits, resets zero
// R06: At 44.1k divide oscillator by field+1
// R07: Fraction pair forms sixteen bits, resets zero
// R08: Bit clock is oversample over 2(div+1)
// R09: 32 or 64 bit clocks per frame
// R10: Bit clock divider resets to three
// R11: Bit six chooses LSB or MSB first
// R12: Bit five pads left or right, wide only
// R13: Bit four sets word select polarity
// R14: Host sets polarity one for standard I2S
// R15: Bit three chooses standard or alternate format
// R16: Bit two chooses bit clock data edge
// R17: Bits one-zero choose 16/18/20/24 bit samples
// R18: Output configuration resets to 0x21
// R19: 32 bits narrow, 64 bits wide per frame
// R20: Steps beyond largest tabulated value mute
`timescale 1ns/100ps
`include "pcmo_cfg.svh"

module pcmo_top
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 soft_reset,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    output logic      [7:0]           reg_rdata,
    // PLL settings
    input  wire logic                 is_44k1,
    output logic      [5:0]           pll_x_divisor,
    output logic      [15:0]          pll_frac,
    output logic                      pll_cfg_active,
    // Decoded samples
    input  wire logic                 sample_valid,
    input  wire pcmo_pkg::pcmo_pair_t sample_in,
    output logic                      sample_ready,
    // Serial output
    output logic                      serial_bit_clock,
    output logic                      word_select_clock,
    output logic                      serial_data
);

    logic                 rst_any;
    logic [7:0]           att_right_reg;
    logic [7:0]           mix_r2l_reg;
    logic [4:0]           pll_div441_reg;
    logic [7:0]           frac_l_reg;
    logic [7:0]           frac_h_reg;
    logic [7:0]           bclk_div_reg;
    pcmo_pkg::pcmo_cfg_t  cfg_reg;
    logic [7:0]           rdata_next;
    logic signed [23:0]   right_att;
    logic signed [23:0]   right_mix;
    logic signed [24:0]   left_sum;
    logic signed [23:0]   left_sat;
    pcmo_pkg::pcmo_pair_t pend_reg;
    logic                 pend_full_reg;
    pcmo_pkg::pcmo_pair_t frame_reg;
    pcmo_pkg::pcmo_pair_t frame_next;
    logic [7:0]           div_cnt_reg;
    logic                 tick;
    logic                 change_evt;
    logic                 bclk_reg;
    logic [5:0]           bit_cnt_reg;
    logic [5:0]           bit_cnt_next;
    logic [5:0]           pos_next;
    logic                 load;
    logic                 ws_reg;
    logic                 sdata_reg;
    logic                 bit_next;
    logic                 frame_clean_reg;

    assign rst_any = !nrst || soft_reset;

    function automatic logic [5:0] slot_bits(input pcmo_pkg::pcmo_width_t w);
        slot_bits = (w == pcmo_pkg::PCMO_W16) ? `PCMO_SLOT_16 : `PCMO_SLOT_WIDE;
    endfunction

    function automatic logic [5:0] frame_last(input pcmo_pkg::pcmo_width_t w);
        frame_last = (w == pcmo_pkg::PCMO_W16) ? `PCMO_FRAME_LAST_16 : `PCMO_FRAME_LAST_WIDE;
    endfunction

    function automatic logic [5:0] word_bits(input pcmo_pkg::pcmo_width_t w);
        case (w)
            pcmo_pkg::PCMO_W16: word_bits = 6'h10;  // see R17
            pcmo_pkg::PCMO_W18: word_bits = 6'h12;
            pcmo_pkg::PCMO_W20: word_bits = 6'h14;
            default:            word_bits = 6'h18;
        endcase
    endfunction

    // Register writes; software reset restores the same values as the pin reset
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            att_right_reg  <= `PCMO_RST_ATT_RIGHT;
            mix_r2l_reg    <= `PCMO_RST_MIX_R2L;             // see R04
            pll_div441_reg <= `PCMO_RST_PLL_DIV441;          // see R05
            frac_l_reg     <= `PCMO_RST_FRAC441;             // see R07
            frac_h_reg     <= `PCMO_RST_FRAC441;
            bclk_div_reg   <= `PCMO_RST_BCLK_DIV;            // see R10
            cfg_reg        <= `PCMO_RST_OUT_CFG;             // see R18 see R15
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `PCMO_ADDR_ATT_RIGHT:  att_right_reg  <= reg_wdata;
                `PCMO_ADDR_MIX_R2L:    mix_r2l_reg    <= reg_wdata;
                `PCMO_ADDR_PLL_DIV441: pll_div441_reg <= reg_wdata[`PCMO_PLL_DIV_W-1:0];  // see R05
                `PCMO_ADDR_FRAC441_L:  frac_l_reg     <= reg_wdata;
                `PCMO_ADDR_FRAC441_H:  frac_h_reg     <= reg_wdata;
                `PCMO_ADDR_BCLK_DIV:   bclk_div_reg   <= reg_wdata;
                `PCMO_ADDR_OUT_CFG:    cfg_reg        <= reg_wdata[6:0];
                default:               cfg_reg        <= cfg_reg;
            endcase
        end
    end

    // Read mux; unused bits and unmapped addresses read zero
    always_comb
    begin
        case (reg_addr)
            `PCMO_ADDR_ATT_RIGHT:  rdata_next = att_right_reg;
            `PCMO_ADDR_MIX_R2L:    rdata_next = mix_r2l_reg;
            `PCMO_ADDR_PLL_DIV441: rdata_next = {3'h0, pll_div441_reg};
            `PCMO_ADDR_FRAC441_L:  rdata_next = frac_l_reg;
            `PCMO_ADDR_FRAC441_H:  rdata_next = frac_h_reg;
            `PCMO_ADDR_BCLK_DIV:   rdata_next = bclk_div_reg;
            `PCMO_ADDR_OUT_CFG:    rdata_next = {1'b0, cfg_reg};
            default:               rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rdata_next;
    end

    // PLL settings only apply while the stream is at 44.1 kHz
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            pll_x_divisor  <= 6'h00;
            pll_frac       <= 16'h0000;
            pll_cfg_active <= 1'b0;
        end
        else
        begin
            pll_x_divisor  <= is_44k1 ? ({1'b0, pll_div441_reg} + 6'h01) : 6'h00;  // see R06
            pll_frac       <= is_44k1 ? {frac_h_reg, frac_l_reg} : 16'h0000;      // see R07
            pll_cfg_active <= is_44k1;
        end
    end

    // Level path: right attenuated, right mixed onto left
    pcmo_atten u_att_right
    (
        .din   (sample_in.right),
        .dout  (right_att),
        .level (att_right_reg)
    );

    pcmo_atten u_mix_r2l
    (
        .din   (sample_in.right),
        .dout  (right_mix),
        .level (mix_r2l_reg)
    );

    // Saturate rather than wrap so a hot mix clips instead of flipping sign
    always_comb
    begin
        left_sum = 25'(sample_in.left) + 25'(right_mix);  // see R03
        if (left_sum[24] != left_sum[23])
            left_sat = left_sum[24] ? 24'sh800000 : 24'sh7FFFFF;
        else
            left_sat = left_sum[23:0];
    end

    // One pending pair; the source stalls until the frame takes it
    assign sample_ready = !pend_full_reg;

    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            pend_reg      <= '0;
            pend_full_reg <= 1'b0;
        end
        else if (sample_valid && !pend_full_reg)
        begin
            pend_reg.left  <= left_sat;
            pend_reg.right <= right_att;  // see R01
            pend_full_reg  <= 1'b1;
        end
        else if (load)
            pend_full_reg <= 1'b0;
    end

    // Bit clock divider: toggle every div+1 clocks
    assign tick       = (div_cnt_reg >= bclk_div_reg);
    assign change_evt = tick && (bclk_reg != cfg_reg.edge_select);  // see R16

    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            div_cnt_reg <= 8'h00;
            bclk_reg    <= 1'b0;
        end
        else if (reg_wr && reg_addr == `PCMO_ADDR_BCLK_DIV)
            div_cnt_reg <= 8'h00;  // Restart so the count never sits above a lowered divider
        else if (tick)
        begin
            div_cnt_reg <= 8'h00;
            bclk_reg    <= !bclk_reg;  // see R08
        end
        else
            div_cnt_reg <= div_cnt_reg + 8'h01;
    end

    // Frame position; standard format delays data one bit behind word select
    always_comb
    begin
        if (bit_cnt_reg >= frame_last(cfg_reg.sample_width_select))
            bit_cnt_next = 6'h00;  // see R09 see R19
        else
            bit_cnt_next = bit_cnt_reg + 6'h01;
        if (cfg_reg.format_select)
            pos_next = bit_cnt_next;  // see R15
        else if (bit_cnt_next == 6'h00)
            pos_next = frame_last(cfg_reg.sample_width_select);
        else
            pos_next = bit_cnt_next - 6'h01;
        load = change_evt && (pos_next == 6'h00);
        frame_next = pend_full_reg ? pend_reg : '0;
    end

    // Serial bit for the next position; underrun sends silence
    always_comb
    begin
        logic                 ch;
        logic [5:0]           slot;
        logic [5:0]           wb;
        logic [5:0]           idx;
        logic [5:0]           off;
        logic [5:0]           j;
        logic signed [23:0]   word;
        ch   = 1'b0;
        slot = slot_bits(cfg_reg.sample_width_select);
        wb   = word_bits(cfg_reg.sample_width_select);
        ch   = (pos_next >= slot);
        idx  = ch ? (pos_next - slot) : pos_next;
        off  = (cfg_reg.justify_select && cfg_reg.sample_width_select != pcmo_pkg::PCMO_W16)
             ? (slot - wb) : 6'h00;  // see R12
        j    = idx - off;
        word = load ? (ch ? frame_next.right : frame_next.left)
                    : (ch ? frame_reg.right : frame_reg.left);
        if (idx < off || idx >= off + wb)
            bit_next = 1'b0;
        else if (cfg_reg.lsb_first_select)
            bit_next = word[5'(6'h18 - wb + j)];  // see R11
        else
            bit_next = word[5'(6'h17 - j)];
    end

    always_ff @(posedge clk)
    begin
        if (rst_any)
            frame_reg <= '0;
        else if (load)
            frame_reg <= frame_next;
    end

    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            bit_cnt_reg <= `PCMO_FRAME_LAST_16;
            ws_reg      <= 1'b1;
            sdata_reg   <= 1'b0;
        end
        else if (change_evt)
        begin
            bit_cnt_reg <= bit_cnt_next;
            ws_reg      <= (bit_cnt_next >= slot_bits(cfg_reg.sample_width_select))
                           ~^ cfg_reg.word_select_polarity;  // see R13 see R14
            sdata_reg   <= bit_next;
        end
    end

    assign serial_bit_clock  = bclk_reg;
    assign word_select_clock = ws_reg;
    assign serial_data       = sdata_reg;

    // A frame cut short by a format write is left out of the length check
    always_ff @(posedge clk)
    begin
        if (rst_any || (reg_wr && reg_addr == `PCMO_ADDR_OUT_CFG))
            frame_clean_reg <= 1'b0;
        else if (change_evt && bit_cnt_next == 6'h00)
            frame_clean_reg <= 1'b1;
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_mix_reset: assert property (soft_reset |=> mix_r2l_reg == 8'hFF)  // see R04
        else $error("mix level not all ones after soft reset");
    a_cfg_reset: assert property (soft_reset |=> cfg_reg == 7'h21 && !cfg_reg.format_select)  // see R18
        else $error("output config not 0x21 after soft reset");
    a_div_reset: assert property (soft_reset |=> bclk_div_reg == 8'h03 && pll_div441_reg == 5'h00)  // see R10
        else $error("divider reset value wrong");
    a_bclk_period: assert property (!soft_reset && $past(!soft_reset) && $changed(bclk_reg) |->  // see R08
                                    $past(div_cnt_reg) == $past(bclk_div_reg))
        else $error("bit clock toggled off its divider count");
    a_frame_len: assert property (!soft_reset && $changed(bit_cnt_reg) && bit_cnt_reg == 6'h00
                                  && $stable(cfg_reg) && $past(frame_clean_reg) |->
                                  $past(bit_cnt_reg) == frame_last(cfg_reg.sample_width_select))  // see R19
        else $error("frame length not 32 or 64 bits");
    a_data_edge: assert property (!soft_reset && $past(!soft_reset) && $changed(sdata_reg) |->
                                  $past(change_evt) && bclk_reg == $past(cfg_reg.edge_select))  // see R16
        else $error("serial data changed on the wrong bit clock edge");
    a_mute_full: assert property (sample_valid && sample_ready && att_right_reg == 8'hFF && !soft_reset
                                  |=> pend_reg.right == 24'sh000000)  // see R02
        else $error("full attenuation did not mute right");
    a_zero_att: assert property (sample_valid && sample_ready && att_right_reg == 8'h00 && !soft_reset
                                 |=> pend_reg.right == $past(sample_in.right))  // see R01
        else $error("zero attenuation altered right sample");
    a_ws_polarity: assert property (!soft_reset && $past(change_evt) && $stable(cfg_reg) && bit_cnt_reg == 6'h01
                                    |-> ws_reg == !cfg_reg.word_select_polarity)  // see R13
        else $error("left word select level wrong");
    a_pll_div: assert property (is_44k1 && !soft_reset && $stable(pll_div441_reg) |=>
                                pll_x_divisor == {1'b0, $past(pll_div441_reg)} + 6'h01)  // see R06
        else $error("44.1 kHz divisor not field plus one");
    a_pad_left: assert property (!soft_reset && $past(change_evt) && $stable(cfg_reg) && cfg_reg.justify_select
                                 && cfg_reg.format_select && cfg_reg.sample_width_select == pcmo_pkg::PCMO_W20
                                 && bit_cnt_reg < 6'h0C |-> !sdata_reg)  // see R12
        else $error("left padding bits not zero");

    c_frame_16: cover property (change_evt && bit_cnt_reg == 6'h1F && cfg_reg.sample_width_select == 2'b00);
    c_frame_24: cover property (change_evt && bit_cnt_reg == 6'h3F && cfg_reg.sample_width_select == 2'b11);
    c_lsb_first: cover property (load && cfg_reg.lsb_first_select);
    c_underrun: cover property (load && !pend_full_reg);

endmodule // pcmo_top

// File: verification/pcmo_dac_model.sv
// Behavioural serial DAC that listens to the PCM output block and keeps what it received.
// Assumes the stream is registered on clk, so both bit clock edges are seen in the clk domain.
`timescale 1ns/100ps

module pcmo_dac_model
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Serial link
    input  wire logic        serial_bit_clock,
    input  wire logic        word_select_clock,
    input  wire logic        serial_data,
    // Receiver setup
    input  wire logic        left_level,
    input  wire logic        sample_level,
    // Captured results
    output logic      [31:0] left_word,
    output logic      [31:0] right_word,
    output logic      [7:0]  frame_bits,
    output logic      [7:0]  bclk_period
);
    logic        bclk_d;
    logic        ws_d;
    logic [31:0] sr;
    logic [7:0]  fcnt;
    logic [7:0]  pcnt;

    // Sampling on the clk edge after the bit clock moved sees values settled half a bit earlier,
    // so data launched on the wrong bit clock edge shows up as a one-bit shift
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            bclk_d      <= 1'b0;
            ws_d        <= 1'b1;
            sr          <= 32'h0;
            fcnt        <= 8'h0;
            pcnt        <= 8'h0;
            left_word   <= 32'h0;
            right_word  <= 32'h0;
            frame_bits  <= 8'h0;
            bclk_period <= 8'h0;
        end
        else
        begin
            bclk_d <= serial_bit_clock;
            pcnt   <= pcnt + 8'h1;
            if (serial_bit_clock && !bclk_d)
            begin
                bclk_period <= pcnt + 8'h1;
                pcnt        <= 8'h0;
            end
            if ((serial_bit_clock != bclk_d) && (serial_bit_clock == sample_level))
            begin
                fcnt <= fcnt + 8'h1;
                ws_d <= word_select_clock;
                if (word_select_clock != ws_d)
                begin
                    if (ws_d == left_level)
                        left_word <= sr;
                    else
                        right_word <= sr;
                    sr <= {31'h0, serial_data};
                    if (word_select_clock == left_level)
                    begin
                        frame_bits <= fcnt;
                        fcnt       <= 8'h1;
                    end
                end
                else
                    sr <= {sr[30:0], serial_data};
            end
        end
    end
endmodule // pcmo_dac_model

// File: verification/pcm_output_config_tb_top.sv
// Self-checking bench for the PCM output block: registers, PLL outputs, bit clock and framing.
// Assumes the block's header and package are compiled first and the DAC model beside it.
`timescale 1ns/100ps

module pcm_output_config_tb_top;
    localparam int LIMIT = 20000;
    logic                 clk;
    logic                 nrst;
    logic                 soft_reset;
    logic [7:0]           reg_addr;
    logic [7:0]           reg_wdata;
    logic                 reg_wr;
    logic [7:0]           reg_rdata;
    logic                 is_44k1;
    logic [5:0]           pll_x_divisor;
    logic [15:0]          pll_frac;
    logic                 pll_cfg_active;
    logic                 sample_valid;
    pcmo_pkg::pcmo_pair_t sample_in;
    logic                 sample_ready;
    logic                 serial_bit_clock;
    logic                 word_select_clock;
    logic                 serial_data;
    logic                 left_level;
    logic                 sample_level;
    logic [31:0]          left_word;
    logic [31:0]          right_word;
    logic [7:0]           frame_bits;
    logic [7:0]           bclk_period;
    int                   mismatches;
    int                   tests_run;
    int                   cycles;
    logic [7:0]           ra [8] = '{8'h48, 8'h49, 8'h50, 8'h51, 8'h52, 8'h54, 8'h55, 8'h53};
    logic [7:0]           rv [8] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h03, 8'h21, 8'h00};
    logic [7:0]           fmt [6] = '{8'h30, 8'h21, 8'h3E, 8'h5B, 8'h27, 8'h52};
    logic [7:0]           lat [5] = '{8'h06, 8'hFF, 8'h61, 8'h00, 8'h00};
    logic [7:0]           lmx [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h06};
    logic [23:0]          lin [5] = '{24'h100000, 24'h100000, 24'h100000, 24'h400000, 24'h100000};
    logic [23:0]          lel [5] = '{24'h100000, 24'h100000, 24'h100000, 24'h7FFFFF, 24'h300000};
    logic [23:0]          ler [5] = '{24'h200000, 24'h000000, 24'h000000, 24'h400000, 24'h400000};

    pcmo_top dut
    (
        .clk               (clk),
        .nrst              (nrst),
        .soft_reset        (soft_reset),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_wr            (reg_wr),
        .reg_rdata         (reg_rdata),
        .is_44k1           (is_44k1),
        .pll_x_divisor     (pll_x_divisor),
        .pll_frac          (pll_frac),
        .pll_cfg_active    (pll_cfg_active),
        .sample_valid      (sample_valid),
        .sample_in         (sample_in),
        .sample_ready      (sample_ready),
        .serial_bit_clock  (serial_bit_clock),
        .word_select_clock (word_select_clock),
        .serial_data       (serial_data)
    );

    pcmo_dac_model dac
    (
        .clk               (clk),
        .nrst              (nrst),
        .serial_bit_clock  (serial_bit_clock),
        .word_select_clock (word_select_clock),
        .serial_data       (serial_data),
        .left_level        (left_level),
        .sample_level      (sample_level),
        .left_word         (left_word),
        .right_word        (right_word),
        .frame_bits        (frame_bits),
        .bclk_period       (bclk_period)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic finish_test;
        $display("counts: %0d comparisons, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == LIMIT)
        begin
            mismatches = mismatches + 1;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    // Read data is registered, so it is taken one cycle after the address
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        check(32'(reg_rdata), 32'(exp));
    endtask

    function automatic logic slot_bit(input logic [7:0] cfg, input logic [23:0] s, input int p);
        int w;
        int slot;
        int off;
        w    = (cfg[1:0] == 2'h0) ? 16 : (cfg[1:0] == 2'h1) ? 18 : (cfg[1:0] == 2'h2) ? 20 : 24;
        slot = (cfg[1:0] == 2'h0) ? 16 : 32;
        off  = (cfg[5] && slot == 32) ? slot - w : 0;
        if (p < off || p >= off + w)
            return 1'b0;
        return cfg[6] ? s[24 - w + p - off] : s[23 - p + off];
    endfunction

    // First received bit lands highest; standard format carries the other slot's last bit first
    function automatic logic [31:0] exp_half(input logic [7:0] cfg, input logic [23:0] s, input logic [23:0] o);
        logic [31:0] r;
        int          slot;
        r    = 32'h0;
        slot = (cfg[1:0] == 2'h0) ? 16 : 32;
        for (int i = 0; i < slot; i++)
            r = {r[30:0], cfg[3] ? slot_bit(cfg, s, i) : (i == 0 ? slot_bit(cfg, o, slot - 1) : slot_bit(cfg, s, i - 1))};
        return r;
    endfunction

    task automatic ser_check(input logic [7:0] cfg, input logic [23:0] l, input logic [23:0] r,
                             input logic [23:0] el, input logic [23:0] er);
        wr_reg(8'h55, cfg);
        left_level   = ~cfg[4];
        sample_level = ~cfg[2];
        sample_in    = {l, r};
        repeat (700) @(negedge clk);
        check(left_word, exp_half(cfg, el, er));
        check(right_word, exp_half(cfg, er, el));
        check(32'(frame_bits), (cfg[1:0] == 2'h0) ? 32'h20 : 32'h40);
    endtask

    initial
    begin
        nrst         = 1'b0;
        soft_reset   = 1'b0;
        reg_addr     = 8'h00;
        reg_wdata    = 8'h00;
        reg_wr       = 1'b0;
        is_44k1      = 1'b0;
        sample_valid = 1'b0;
        sample_in    = '0;
        left_level   = 1'b1;
        sample_level = 1'b1;
        mismatches   = 0;
        tests_run    = 0;
        cycles       = 0;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 8; i++)
            rd_check(ra[i], rv[i]);
        repeat (40) @(negedge clk);
        check(32'(bclk_period), 32'h08);
        check(32'(sample_ready), 32'h1);
        $display("test reset_values done");
        wr_reg(8'h50, 8'hFF);
        rd_check(8'h50, 8'h1F);
        wr_reg(8'h50, 8'h05);
        wr_reg(8'h51, 8'h34);
        wr_reg(8'h52, 8'h12);
        @(negedge clk);
        is_44k1 = 1'b1;
        repeat (3) @(negedge clk);
        check(32'(pll_x_divisor), 32'h06);
        check(32'(pll_frac), 32'h1234);
        check(32'(pll_cfg_active), 32'h1);
        is_44k1 = 1'b0;
        repeat (3) @(negedge clk);
        check(32'(pll_x_divisor), 32'h00);
        wr_reg(8'h54, 8'h05);
        repeat (60) @(negedge clk);
        check(32'(bclk_period), 32'h0C);
        $display("test pll_and_divider done");
        wr_reg(8'h55, 8'hFF);
        wr_reg(8'h49, 8'h10);
        @(negedge clk);
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
        rd_check(8'h55, 8'h21);
        rd_check(8'h49, 8'hFF);
        rd_check(8'h54, 8'h03);
        rd_check(8'h50, 8'h00);
        rd_check(8'h52, 8'h00);
        $display("test soft_reset done");
        // Fastest bit clock keeps each frame short
        wr_reg(8'h54, 8'h00);
        sample_valid = 1'b1;
        for (int i = 0; i < 6; i++)
            ser_check(fmt[i], 24'hC3A55A, 24'h5A3C96, 24'hC3A55A, 24'h5A3C96);
        $display("test serial_formats done");
        for (int i = 0; i < 5; i++)
        begin
            wr_reg(8'h48, lat[i]);
            wr_reg(8'h49, lmx[i]);
            ser_check(8'h13, lin[i], 24'h400000, lel[i], ler[i]);
        end
        $display("test levels done");
        finish_test();
    end
endmodule // pcm_output_config_tb_top
